// ==== bench/adsri_host_model.sv ====
// host-side serial master model for the register front end
// assumes the bench calls its tasks; serial clock idles low
`timescale 1ns/1ps
module adsri_host_model (
    // serial pins
    output logic sclk_o,
    output logic cs_n_o,
    output logic din_o,
    input wire logic dout_i
);
    localparam realtime HALF = 24.0;
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        din_o = 1'b0;
    end
    ////////////////////////////////////////////////////////////
    // one bit group, msb first; dout taken late in the high phase
    task automatic shift(input logic [23:0] wd, input int n, input logic lo,
                         output logic [23:0] rd);
        rd = '0;
        for (int i = n - 1; i >= 0; i--) begin
            din_o = lo ? 1'b0 : wd[i];
            #(HALF);
            sclk_o = 1'b1;
            #(HALF);
            rd[i] = dout_i;
            sclk_o = 1'b0;
        end
    endtask
    task automatic xfer(input logic [7:0] cmd, input int n, input logic [23:0] wd,
                        output logic [23:0] rd);
        logic [23:0] junk;
        cs_n_o = 1'b0;
        shift({16'h0, 1'b0, cmd[6:0]}, 8, 1'b0, junk);
        shift(wd, n, cmd[6], rd);
        din_o = ~din_o;
        #(HALF * 4);
        cs_n_o = 1'b1;
        #(HALF * 2);
    endtask
    task automatic ones(input int n);
        logic [23:0] junk;
        cs_n_o = 1'b0;
        for (int i = 0; i < n; i++) shift(24'h1, 1, 1'b0, junk);
        #(HALF * 4);
        cs_n_o = 1'b1;
        #(HALF * 2);
    endtask
endmodule

// ==== bench/tb_top.sv ====
// self-checking bench for the serial register front end
// assumes the host model drives the serial pins
`timescale 1ns/1ps
module tb_top import adsri_pkg::*;;
    localparam logic [3:0] REV = 4'h3;  // arbitrary value
    localparam logic [3:0] PART = 4'h6; // arbitrary value
    logic clk_i, rst_i, reset_n_i, sclk_i, cs_n_i, din_i, dout_o, rdy_n_o;
    logic gpio_a_i, gpio_a_o, gpio_a_oe_o, gpio_b_i, gpio_b_o, gpio_b_oe_o;
    logic sync_o, cal_done_i, soft_reset_o, mode_start_o;
    logic [3:0] conv_done_i, chan_enable_o;
    logic [3:0][23:0] result_i;
    logic [3:0][2:0] chan_flags_i;
    logic [1:0] mode_chan_o, ch;
    logic [2:0] md;
    adsri_mode_t mode_o;
    adsri_range_t [3:0] chan_range_o;
    int n_fail = 0;
    int checks_done = 0;
    int n_start = 0;
    int n_soft = 0;
    always @(negedge clk_i) begin
        n_start += int'(mode_start_o === 1'b1);
        n_soft += int'(soft_reset_o === 1'b1);
    end
    always #2.5 clk_i = ~clk_i;
    adsri_core #(.REV_CODE(REV), .PART_CODE(PART)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .reset_n_i(reset_n_i), .sclk_i(sclk_i),
        .cs_n_i(cs_n_i), .din_i(din_i), .dout_o(dout_o), .rdy_n_o(rdy_n_o),
        .gpio_a_i(gpio_a_i), .gpio_a_o(gpio_a_o), .gpio_a_oe_o(gpio_a_oe_o),
        .gpio_b_i(gpio_b_i), .gpio_b_o(gpio_b_o), .gpio_b_oe_o(gpio_b_oe_o),
        .sync_o(sync_o), .conv_done_i(conv_done_i), .cal_done_i(cal_done_i),
        .result_i(result_i), .chan_flags_i(chan_flags_i),
        .soft_reset_o(soft_reset_o), .mode_o(mode_o), .mode_chan_o(mode_chan_o),
        .mode_start_o(mode_start_o), .chan_enable_o(chan_enable_o),
        .chan_range_o(chan_range_o)
    );
    adsri_host_model i_host (
        .sclk_o(sclk_i), .cs_n_o(cs_n_i), .din_o(din_i), .dout_i(dout_o)
    );
    ////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input int n, input logic [23:0] d);
        logic [23:0] r;
        @(negedge clk_i);
        i_host.xfer({2'b00, a}, n, d, r);
    endtask
    task automatic rd_chk(input logic [5:0] a, input int n, input logic [23:0] e);
        logic [23:0] r;
        @(negedge clk_i);
        i_host.xfer({2'b01, a}, n, 24'h0, r);
        check(r, e);
    endtask
    task automatic wait_rdy(input logic lvl);
        int k;
        k = 0;
        while (rdy_n_o !== lvl && k < 50) begin
            @(posedge clk_i);
            k++;
        end
        check({23'h0, rdy_n_o}, {23'h0, lvl});
        if (rdy_n_o !== lvl) print_verdict();
    endtask
    task automatic pulse(input logic [3:0] m, input logic cal);
        @(negedge clk_i);
        conv_done_i = m;
        cal_done_i = cal;
        @(negedge clk_i);
        conv_done_i = 4'h0;
        cal_done_i = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        reset_n_i = 1'b1;
        gpio_a_i = 1'b1;
        gpio_b_i = 1'b0;
        conv_done_i = 4'h0;
        cal_done_i = 1'b0;
        chan_flags_i = '0;
        result_i = '0;
        result_i[1] = 24'h5a3c7e;
        repeat (10) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (8) @(negedge clk_i);
        rd_chk(6'h01, 8, 24'hb0);
        check({22'h0, gpio_a_o, gpio_b_o}, 24'h2);
        check({22'h0, gpio_a_oe_o, gpio_b_oe_o}, 24'h0);
        rd_chk(6'h02, 8, {16'h0, REV, PART});
        wr(6'h02, 8, 24'hff);
        rd_chk(6'h02, 8, {16'h0, REV, PART});
        rd_chk(6'h00, 8, 24'h0);
        wr(6'h01, 8, 24'hc6);
        check({20'h0, gpio_a_o, gpio_b_o, gpio_a_oe_o, gpio_b_oe_o}, 24'hf);
        rd_chk(6'h01, 8, 24'hc0);
        wr(6'h01, 8, 24'h31);
        rd_chk(6'h01, 8, 24'hb1);
        gpio_b_i = 1'b1;
        repeat (6) @(negedge clk_i);
        check({23'h0, sync_o}, 24'h1);
        wr(6'h01, 8, 24'h30);
        check({23'h0, sync_o}, 24'h0);
        wr(6'h10, 24, 24'h123456);
        wr(6'h13, 24, 24'habcdef);
        rd_chk(6'h10, 24, 24'h123456);
        rd_chk(6'h13, 24, 24'habcdef);
        wr(6'h05, 16, 24'hbeef);
        rd_chk(6'h05, 16, 24'hbeef);
        for (int c = 0; c < 4; c++) begin
            ch = 2'(c);
            wr({4'ha, ch}, 8, {16'h0, 4'h0, ~ch[0], 1'b0, ch});
            check({22'h0, chan_range_o[ch]}, {22'h0, ch});
        end
        check({20'h0, chan_enable_o}, 24'h5);
        for (int m = 0; m < 8; m++) begin
            md = 3'(m);
            wr({4'he, md[1:0]}, 8, {16'h0, md, 5'h0});
            check({19'h0, mode_o.mode_sel, mode_chan_o}, {19'h0, md, md[1:0]});
        end
        check(24'(n_start), 24'h8);
        rd_chk(6'h38, 8, 24'he0);
        rd_chk(6'h3b, 8, 24'h0);
        wr(6'h38, 8, 24'h20);
        wait_rdy(1'b1);
        pulse(4'h2, 1'b0);
        wait_rdy(1'b0);
        rd_chk(6'h09, 16, 24'h5a3c);
        wait_rdy(1'b1);
        wr(6'h01, 8, 24'h38);
        pulse(4'h1, 1'b0);
        repeat (10) @(negedge clk_i);
        check({23'h0, rdy_n_o}, 24'h1);
        pulse(4'h4, 1'b0);
        wait_rdy(1'b0);
        wr(6'h04, 8, 24'hff);
        rd_chk(6'h04, 8, 24'h05);
        wr(6'h38, 8, 24'h80);
        wait_rdy(1'b1);
        pulse(4'h0, 1'b1);
        wait_rdy(1'b0);
        wr(6'h38, 8, 24'h22);
        rd_chk(6'h09, 24, 24'h5a3c7e);
        i_host.ones(32);
        repeat (8) @(negedge clk_i);
        check(24'(n_soft), 24'h1);
        rd_chk(6'h38, 8, 24'h0);
        rd_chk(6'h01, 8, 24'hf0);
        wr(6'h38, 8, 24'h20);
        reset_n_i = 1'b0;
        repeat (10) @(negedge clk_i);
        reset_n_i = 1'b1;
        repeat (8) @(negedge clk_i);
        rd_chk(6'h38, 8, 24'h0);
        check({23'h0, rdy_n_o}, 24'h1);
        print_verdict();
    end
endmodule

// ==== inc/adsri_consts.svh ====
// constants of the serial register interface: addresses, fields, resets
// assumes inclusion by bare name from the design file
`ifndef ADSRI_CONSTS_SVH
`define ADSRI_CONSTS_SVH
// single addresses
`define ADSRI_A_CMD 6'h00
`define ADSRI_A_PORT 6'h01
`define ADSRI_A_REV 6'h02
`define ADSRI_A_TEST 6'h03
`define ADSRI_A_RDYF 6'h04
`define ADSRI_A_CSUM 6'h05
`define ADSRI_A_AZERO 6'h06
`define ADSRI_A_AGAIN 6'h07
`define ADSRI_A_MODE 6'h38
// per-channel groups, address bits 5..2
`define ADSRI_G_DATA 4'h2
`define ADSRI_G_CZERO 4'h4
`define ADSRI_G_CGAIN 4'h6
`define ADSRI_G_CFLAG 4'h8
`define ADSRI_G_CCFG 4'ha
`define ADSRI_G_CTIME 4'hc
`define ADSRI_G_MODE 4'he
// port register fields
`define ADSRI_P_A 7
`define ADSRI_P_B 6
`define ADSRI_P_DIR_A 5
`define ADSRI_P_DIR_B 4
`define ADSRI_P_PENDING_ALL_SELECT 3
`define ADSRI_P_SYNC 0
`define ADSRI_PORT_MASK 8'hf9
`define ADSRI_PORT_RST 8'h30
// channel setup fields
`define ADSRI_C_SOPT 4
`define ADSRI_C_EN 3
`define ADSRI_CCFG_MASK 8'h1b
// reset values
`define ADSRI_COEF_MID 24'h800000
`define ADSRI_CGAIN_RST 24'h200000
`define ADSRI_CTIME_RST 8'h91
`define ADSRI_SYNC_RST 6'h0a
// counts and widths
`define ADSRI_ONES 6'h20
`define ADSRI_W8 5'h08
`define ADSRI_W16 5'h10
`define ADSRI_W24 5'h18
`define ADSRI_LAST_CMD 5'h07
`define ADSRI_STRAP_WAIT 3'h4
`endif

// ==== inc/adsri_pkg.sv ====
// types shared by the serial register interface
// assumes nothing beyond a SystemVerilog compiler
package adsri_pkg;
    typedef enum logic [2:0] {
        MD_IDLE, MD_CONT, MD_SINGLE, MD_STANDBY,
        MD_ADC_ZS_CAL, MD_SPARE, MD_CH_ZS_CAL, MD_CH_FS_CAL
    } adsri_mode_sel_t;
    typedef enum logic [1:0] {
        RNG_BI_10V, RNG_UNI_10V, RNG_BI_5V, RNG_UNI_5V
    } adsri_range_t;
    typedef enum logic [1:0] {ST_CMD, ST_WR, ST_RD} adsri_state_t;
    typedef struct packed {
        logic must_zero;
        logic rd;
        logic [5:0] addr;
    } adsri_cmd_t;
    typedef struct packed {
        adsri_mode_sel_t mode_sel;
        logic clock_out_off;
        logic dump;
        logic cont_rd;
        logic wide;
        logic clamp;
    } adsri_mode_t;
endpackage

// ==== verilog/adsri_core.sv ====
// serial register front end and control register map of the converter
// assumes pins arrive asynchronous to clk_i; converter core outside
// Notes on behaviour
// - every access starts with a command byte
// - command bit 6 picks write or read
// - bits 5..0 address; two LSBs pick channel
// - after reset or transfer, expect command byte
// - 32 ones with select low reset everything
// - mode written at 38h-3Bh, read at 38h
// - mode field encodes eight operating modes
// - data transfer lasts the register width exactly
// - shifted data lands in, or comes from, target
// - port bits drive outputs, read input pins
// - direction bits: 1 input, 0 output, reset 1
// - ready pin: any pending, or all enabled
// - calibration end shown by ready falling edge
// - port bit 0 turns pin into sync input
// - port resets to 30h plus pin levels
// - revision reads revision and part code
// - range field encodes four input ranges
// - reset pin returns everything to power-on state
`timescale 1ns/1ps
`include "adsri_consts.svh"
module adsri_core import adsri_pkg::*; #(
    parameter logic [3:0] REV_CODE = 4'h1,  // arbitrary value
    parameter logic [3:0] PART_CODE = 4'h9  // arbitrary value
) (
    // system
    input wire logic clk_i,
    input wire logic rst_i,
    // serial pins
    input wire logic reset_n_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic din_i,
    output logic dout_o,
    output logic rdy_n_o,
    // general-purpose pins
    input wire logic gpio_a_i,
    output logic gpio_a_o,
    output logic gpio_a_oe_o,
    input wire logic gpio_b_i,
    output logic gpio_b_o,
    output logic gpio_b_oe_o,
    output logic sync_o,
    // converter core
    input wire logic [3:0] conv_done_i,
    input wire logic cal_done_i,
    input wire logic [3:0][23:0] result_i,
    input wire logic [3:0][2:0] chan_flags_i,
    output logic soft_reset_o,
    output adsri_mode_t mode_o,
    output logic [1:0] mode_chan_o,
    output logic mode_start_o,
    output logic [3:0] chan_enable_o,
    output adsri_range_t [3:0] chan_range_o
);

////////////////////////////////////////////////////////////////////////
// pin synchronisers: bit 0 sclk, 1 cs_n, 2 din, 3 reset_n, 4/5 gpio
logic [5:0] s1_reg, s2_reg, s3_reg, filt_reg;
logic sclk_q_reg;
logic [5:0] pins;
assign pins = {gpio_b_i, gpio_a_i, reset_n_i, din_i, cs_n_i, sclk_i};

always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
        s1_reg <= `ADSRI_SYNC_RST;
        s2_reg <= `ADSRI_SYNC_RST;
        s3_reg <= `ADSRI_SYNC_RST;
        filt_reg <= `ADSRI_SYNC_RST;
        sclk_q_reg <= 1'b0;
    end else begin
        s1_reg <= pins;
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        filt_reg <= (s3_reg & ~(s2_reg ^ s3_reg)) | (filt_reg & (s2_reg ^ s3_reg));
        sclk_q_reg <= filt_reg[0];
    end
end

logic rise, fall, din, clr;
logic [5:0] ones_reg;
// edges only count while selected
assign rise = ~filt_reg[1] & filt_reg[0] & ~sclk_q_reg;
assign fall = ~filt_reg[1] & ~filt_reg[0] & sclk_q_reg;
assign din = filt_reg[2];
assign clr = ~filt_reg[3] | (ones_reg == `ADSRI_ONES);
assign soft_reset_o = clr;

// consecutive ones counter
always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
        ones_reg <= 6'h00;
    end else if (clr) begin
        ones_reg <= 6'h00;
    end else if (rise) begin
        ones_reg <= din ? 6'(ones_reg + 6'h01) : 6'h00;
    end
end

////////////////////////////////////////////////////////////////////////
// serial engine
adsri_state_t state_reg;
logic [4:0] bcnt_reg, width_reg, wid_now;
logic [23:0] in_sr_reg, out_sr_reg, rd_val, wr_data;
adsri_cmd_t cmd_reg, cn;
logic cmd_done, last, wr_stb, data_rd, dout_reg;
logic [3:0] grp;

assign cn = adsri_cmd_t'({in_sr_reg[6:0], din});
assign cmd_done = rise && state_reg == ST_CMD && bcnt_reg == `ADSRI_LAST_CMD;
assign last = bcnt_reg == 5'(width_reg - 5'h01);
assign wr_stb = rise && state_reg == ST_WR && last;
assign wr_data = {in_sr_reg[22:0], din};
assign grp = cmd_reg.addr[5:2];
assign data_rd = cmd_done && cn.rd && cn.addr[5:2] == `ADSRI_G_DATA;

always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
        state_reg <= ST_CMD;
        bcnt_reg <= 5'h00;
        in_sr_reg <= 24'h000000;
        out_sr_reg <= 24'h000000;
        cmd_reg <= '0;
        width_reg <= `ADSRI_W8;
    end else if (clr) begin
        state_reg <= ST_CMD;
        bcnt_reg <= 5'h00;
        in_sr_reg <= 24'h000000;
        out_sr_reg <= 24'h000000;
        cmd_reg <= '0;
        width_reg <= `ADSRI_W8;
    end else if (rise) begin
        in_sr_reg <= {in_sr_reg[22:0], din};
        case (state_reg)
            ST_CMD: begin
                if (bcnt_reg == `ADSRI_LAST_CMD) begin
                    bcnt_reg <= 5'h00;
                    cmd_reg <= cn;
                    width_reg <= wid_now;
                    if (cn.rd) begin
                        state_reg <= ST_RD;
                        out_sr_reg <= rd_val << 5'(`ADSRI_W24 - wid_now);
                    end else if (cn.addr != `ADSRI_A_CMD) begin
                        state_reg <= ST_WR;
                    end
                end else begin
                    bcnt_reg <= 5'(bcnt_reg + 5'h01);
                end
            end
            ST_WR, ST_RD: begin
                if (state_reg == ST_RD) begin
                    out_sr_reg <= {out_sr_reg[22:0], 1'b0};
                end
                if (last) begin
                    bcnt_reg <= 5'h00;
                    state_reg <= ST_CMD;
                end else begin
                    bcnt_reg <= 5'(bcnt_reg + 5'h01);
                end
            end
            default: state_reg <= ST_CMD;
        endcase
    end
end

// output bit changes on the falling serial edge
always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
        dout_reg <= 1'b0;
    end else if (clr) begin
        dout_reg <= 1'b0;
    end else if (fall) begin
        dout_reg <= (state_reg == ST_RD) ? out_sr_reg[23] : 1'b0;
    end
end
assign dout_o = dout_reg;

////////////////////////////////////////////////////////////////////////
// port register with strap capture after reset
logic [7:0] port_reg;
logic [2:0] strap_cnt_reg;
logic strap_done_reg, a_lvl, b_lvl;

// capture waits until the pin filter has settled after reset
always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
        port_reg <= `ADSRI_PORT_RST;
        strap_cnt_reg <= 3'h0;
        strap_done_reg <= 1'b0;
    end else if (clr) begin
        port_reg <= `ADSRI_PORT_RST;
        strap_cnt_reg <= 3'h0;
        strap_done_reg <= 1'b0;
    end else begin
        if (!strap_done_reg) begin
            if (strap_cnt_reg == `ADSRI_STRAP_WAIT) begin
                port_reg[`ADSRI_P_A] <= filt_reg[4];
                port_reg[`ADSRI_P_B] <= filt_reg[5];
                strap_done_reg <= 1'b1;
            end else begin
                strap_cnt_reg <= 3'(strap_cnt_reg + 3'h1);
            end
        end
        if (wr_stb && cmd_reg.addr == `ADSRI_A_PORT) begin
            port_reg <= wr_data[7:0] & `ADSRI_PORT_MASK;
        end
    end
end

// pin level reads back as input when direction is input
assign a_lvl = port_reg[`ADSRI_P_DIR_A] ? filt_reg[4] : port_reg[`ADSRI_P_A];
assign b_lvl = port_reg[`ADSRI_P_DIR_B] ? filt_reg[5] : port_reg[`ADSRI_P_B];
assign gpio_a_o = port_reg[`ADSRI_P_A];
assign gpio_b_o = port_reg[`ADSRI_P_B];
assign gpio_a_oe_o = ~port_reg[`ADSRI_P_DIR_A];
assign gpio_b_oe_o = ~port_reg[`ADSRI_P_DIR_B] & ~port_reg[`ADSRI_P_SYNC];
assign sync_o = port_reg[`ADSRI_P_SYNC] & filt_reg[5];

////////////////////////////////////////////////////////////////////////
// plain storage registers
logic [23:0] test_reg, azero_reg, again_reg;
logic [15:0] csum_reg;
logic [23:0] czero_reg [4];
logic [23:0] cgain_reg [4];
logic [7:0] ccfg_reg [4];
logic [7:0] ctime_reg [4];

always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
        test_reg <= 24'h000000;
        csum_reg <= 16'h0000;
        azero_reg <= `ADSRI_COEF_MID;
        again_reg <= `ADSRI_COEF_MID;
    end else if (clr) begin
        test_reg <= 24'h000000;
        csum_reg <= 16'h0000;
        azero_reg <= `ADSRI_COEF_MID;
        again_reg <= `ADSRI_COEF_MID;
    end else if (wr_stb) begin
        if (cmd_reg.addr == `ADSRI_A_TEST) begin
            test_reg <= wr_data;
        end else if (cmd_reg.addr == `ADSRI_A_CSUM) begin
            csum_reg <= wr_data[15:0];
        end else if (cmd_reg.addr == `ADSRI_A_AZERO) begin
            azero_reg <= wr_data;
        end else if (cmd_reg.addr == `ADSRI_A_AGAIN) begin
            again_reg <= wr_data;
        end
    end
end

always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
        for (int i = 0; i < 4; i++) begin
            czero_reg[i] <= `ADSRI_COEF_MID;
            cgain_reg[i] <= `ADSRI_CGAIN_RST;
            ccfg_reg[i] <= 8'h00;
            ctime_reg[i] <= `ADSRI_CTIME_RST;
        end
    end else if (clr) begin
        for (int i = 0; i < 4; i++) begin
            czero_reg[i] <= `ADSRI_COEF_MID;
            cgain_reg[i] <= `ADSRI_CGAIN_RST;
            ccfg_reg[i] <= 8'h00;
            ctime_reg[i] <= `ADSRI_CTIME_RST;
        end
    end else if (wr_stb) begin
        if (grp == `ADSRI_G_CZERO) begin
            czero_reg[cmd_reg.addr[1:0]] <= wr_data;
        end else if (grp == `ADSRI_G_CGAIN) begin
            cgain_reg[cmd_reg.addr[1:0]] <= wr_data;
        end else if (grp == `ADSRI_G_CCFG) begin
            ccfg_reg[cmd_reg.addr[1:0]] <= wr_data[7:0] & `ADSRI_CCFG_MASK;
        end else if (grp == `ADSRI_G_CTIME) begin
            ctime_reg[cmd_reg.addr[1:0]] <= wr_data[7:0];
        end
    end
end

always_comb begin
    for (int i = 0; i < 4; i++) begin
        chan_enable_o[i] = ccfg_reg[i][`ADSRI_C_EN];
        chan_range_o[i] = adsri_range_t'(ccfg_reg[i][1:0]);
    end
end

////////////////////////////////////////////////////////////////////////
// mode register, one copy behind four addresses
adsri_mode_t mode_reg;
logic [1:0] mode_chan_reg;
logic mode_start_reg, mode_wr, cal_mode;
assign mode_wr = wr_stb && grp == `ADSRI_G_MODE;

always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
        mode_reg <= '0;
        mode_chan_reg <= 2'h0;
        mode_start_reg <= 1'b0;
    end else if (clr) begin
        mode_reg <= '0;
        mode_chan_reg <= 2'h0;
        mode_start_reg <= 1'b0;
    end else begin
        mode_start_reg <= mode_wr;
        if (mode_wr) begin
            mode_reg <= adsri_mode_t'(wr_data[7:0]);
            mode_chan_reg <= cmd_reg.addr[1:0];
        end
    end
end
assign mode_o = mode_reg;
assign mode_chan_o = mode_chan_reg;
assign mode_start_o = mode_start_reg;
assign cal_mode = mode_reg.mode_sel inside {MD_ADC_ZS_CAL, MD_CH_ZS_CAL, MD_CH_FS_CAL};

////////////////////////////////////////////////////////////////////////
// pending-data flags and ready pin
logic [3:0] flags_reg, clr_mask, en;
logic rdy_reg, all_ok, rdy_low;
assign clr_mask = mode_wr ? 4'hf : (data_rd ? 4'(4'h1 << cn.addr[1:0]) : 4'h0);

// a setting event wins over a clear in the same cycle
always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
        flags_reg <= 4'h0;
    end else if (clr) begin
        flags_reg <= 4'h0;
    end else begin
        flags_reg <= (flags_reg & ~clr_mask) | conv_done_i | {4{cal_done_i}};
    end
end

assign en = chan_enable_o;
assign all_ok = (en != 4'h0) && ((en & ~flags_reg) == 4'h0);
// calibration end: all flags set, pin falls
assign rdy_low = cal_mode ? (&flags_reg) :
    (port_reg[`ADSRI_P_PENDING_ALL_SELECT] ? all_ok : (|flags_reg));

always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
        rdy_reg <= 1'b1;
    end else if (clr) begin
        rdy_reg <= 1'b1;
    end else begin
        rdy_reg <= ~rdy_low;
    end
end
assign rdy_n_o = rdy_reg;

////////////////////////////////////////////////////////////////////////
// read mux and width of the addressed register
logic [1:0] c;
always_comb begin
    rd_val = 24'h000000;
    wid_now = `ADSRI_W8;
    c = cn.addr[1:0];
    if (cn.addr == `ADSRI_A_PORT) begin
        rd_val[7:0] = {a_lvl, b_lvl, port_reg[5:0]};
    end else if (cn.addr == `ADSRI_A_REV) begin
        rd_val[7:0] = {REV_CODE, PART_CODE};
    end else if (cn.addr == `ADSRI_A_TEST) begin
        rd_val = test_reg;
        wid_now = `ADSRI_W24;
    end else if (cn.addr == `ADSRI_A_RDYF) begin
        rd_val[3:0] = flags_reg;
    end else if (cn.addr == `ADSRI_A_CSUM) begin
        rd_val[15:0] = csum_reg;
        wid_now = `ADSRI_W16;
    end else if (cn.addr == `ADSRI_A_AZERO) begin
        rd_val = azero_reg;
        wid_now = `ADSRI_W24;
    end else if (cn.addr == `ADSRI_A_AGAIN) begin
        rd_val = again_reg;
        wid_now = `ADSRI_W24;
    end else if (cn.addr[5:2] == `ADSRI_G_DATA) begin
        rd_val = mode_reg.wide ? result_i[c] : {8'h00, result_i[c][23:8]};
        wid_now = mode_reg.wide ? `ADSRI_W24 : `ADSRI_W16;
    end else if (cn.addr[5:2] == `ADSRI_G_CZERO) begin
        rd_val = czero_reg[c];
        wid_now = `ADSRI_W24;
    end else if (cn.addr[5:2] == `ADSRI_G_CGAIN) begin
        rd_val = cgain_reg[c];
        wid_now = `ADSRI_W24;
    end else if (cn.addr[5:2] == `ADSRI_G_CFLAG) begin
        rd_val[7:0] = {1'b0, c,
            ccfg_reg[c][`ADSRI_C_SOPT] & a_lvl,
            ccfg_reg[c][`ADSRI_C_SOPT] ? b_lvl : flags_reg[c],
            chan_flags_i[c]};
    end else if (cn.addr[5:2] == `ADSRI_G_CCFG) begin
        rd_val[7:0] = ccfg_reg[c];
    end else if (cn.addr[5:2] == `ADSRI_G_CTIME) begin
        rd_val[7:0] = ctime_reg[c];
    end else if (cn.addr == `ADSRI_A_MODE) begin
        rd_val[7:0] = mode_reg;
    end
end

////////////////////////////////////////////////////////////////////////
// checks
default clocking cb @(posedge clk_i); endclocking
default disable iff (rst_i);

// serial rises since the command byte, kept apart from bcnt_reg
logic [4:0] seen_reg;
always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
        seen_reg <= 5'h00;
    end else if (clr || cmd_done) begin
        seen_reg <= 5'h00;
    end else if (rise) begin
        seen_reg <= 5'(seen_reg + 5'h01);
    end
end

cmd_return_a: assert property (wr_stb |=> state_reg == ST_CMD)
    else $error("no return to command phase after write");
read_dir_a: assert property (cmd_done && cn.rd && !clr |=> state_reg == ST_RD)
    else $error("read command did not start a read");
write_dir_a: assert property (
    cmd_done && !cn.rd && cn.addr != `ADSRI_A_CMD && !clr |=> state_reg == ST_WR)
    else $error("write command did not start a write");
ones_reset_a: assert property (ones_reg == `ADSRI_ONES |=>
    state_reg == ST_CMD && mode_reg == '0 && flags_reg == 4'h0 && port_reg == `ADSRI_PORT_RST)
    else $error("ones sequence did not reset the block");
rdy_any_a: assert property (
    (flags_reg != 4'h0 && !port_reg[`ADSRI_P_PENDING_ALL_SELECT] && !cal_mode && !clr)[*2] |-> !rdy_n_o)
    else $error("ready pin high with data pending");
cal_fall_a: assert property (
    cal_mode && cal_done_i && !clr && !mode_wr ##1 !clr |=> !rdy_n_o)
    else $error("calibration end not shown on ready pin");
dir_reset_a: assert property (clr |=> !gpio_a_oe_o && !gpio_b_oe_o)
    else $error("pins not inputs after reset");
wr_len_a: assert property (wr_stb |-> 5'(seen_reg + 5'h01) == width_reg)
    else $error("write length differs from register width");
ro_keep_a: assert property (
    wr_stb && cmd_reg.addr == `ADSRI_A_RDYF && conv_done_i == 4'h0 && !cal_done_i
    |=> $stable(flags_reg))
    else $error("write to read-only flags changed them");
port_zero_a: assert property (port_reg[2:1] == 2'h0)
    else $error("reserved port bits set");

read_seen_c: cover property (cmd_done && cn.rd ##[1:300] state_reg == ST_CMD);
write_seen_c: cover property (wr_stb && cmd_reg.addr == `ADSRI_A_PORT);
ones_seen_c: cover property (ones_reg == `ADSRI_ONES);
cal_seen_c: cover property (cal_mode && $fell(rdy_n_o));

endmodule
